// [pfb_regs.svh]
`ifndef PFB_REGS_SVH
`define PFB_REGS_SVH

`define PFB_CLK_NS 8
`define PFB_CYC_UP(t) (((t) + `PFB_CLK_NS - 1) / `PFB_CLK_NS)

`define PFB_T_RANDOM_NS 90
`define PFB_T_SELECT_NS 90
`define PFB_T_PAGE_NS 25
`define PFB_T_RESTART_NS 500
`define PFB_T_RECOVER_NS 50
`define PFB_T_TURN_NS 24
`define PFB_T_WSETUP_NS 16
`define PFB_T_WPULSE_NS 40
`define PFB_T_WHOLD_NS 16

`define PFB_CYC_RANDOM `PFB_CYC_UP(`PFB_T_RANDOM_NS)
`define PFB_CYC_SELECT `PFB_CYC_UP(`PFB_T_SELECT_NS)
`define PFB_CYC_PAGE `PFB_CYC_UP(`PFB_T_PAGE_NS)
`define PFB_CYC_RESTART `PFB_CYC_UP(`PFB_T_RESTART_NS)
`define PFB_CYC_RECOVER `PFB_CYC_UP(`PFB_T_RECOVER_NS)
`define PFB_CYC_TURN `PFB_CYC_UP(`PFB_T_TURN_NS)
`define PFB_CYC_WSETUP `PFB_CYC_UP(`PFB_T_WSETUP_NS)
`define PFB_CYC_WPULSE `PFB_CYC_UP(`PFB_T_WPULSE_NS)
`define PFB_CYC_WHOLD `PFB_CYC_UP(`PFB_T_WHOLD_NS)
`define PFB_SYNC_CYC 3

`define PFB_BUF_WORDS 6'h10
`define PFB_BUF_BYTES 6'h20
`define PFB_PAIR_SETUP_ADDR 22'h000000
`define PFB_PAIR_SETUP_DATA 16'h0000

`endif

// [pfb_pkg.sv]
package pfb_pkg;
  typedef enum logic [2:0] {
    pfb_op_read = 3'h0,
    pfb_op_write = 3'h1,
    pfb_op_pair = 3'h2,
    pfb_op_accel = 3'h3,
    pfb_op_bufld = 3'h4,
    pfb_op_restart = 3'h5
  } pfb_op_t;

  typedef enum logic [8:0] {
    pfb_s_idle = 9'h001,
    pfb_s_rd = 9'h002,
    pfb_s_turn = 9'h004,
    pfb_s_wsu = 9'h008,
    pfb_s_wlo = 9'h010,
    pfb_s_whi = 9'h020,
    pfb_s_rlo = 9'h040,
    pfb_s_rrec = 9'h080,
    pfb_s_rsp = 9'h100
  } pfb_state_t;
endpackage

// [pfb_tmr_if.sv]
`timescale 1ns/1ps
interface pfb_tmr_if;
  logic load;
  logic [15:0] count;
  logic done;
  modport ctl (output load, output count, input done);
  modport tmr (input load, input count, output done);
endinterface

// [pfb_timer.sv]
`timescale 1ns/1ps
module pfb_timer (
  input wire logic sys_clk,
  input wire logic reset_n,
  pfb_tmr_if.tmr tif
);
  logic [15:0] cnt_ff;
  logic busy_ff;

  // done fires in the count-th cycle after load
  // done must not look at load: the controller reloads on done, which would loop
  assign tif.done = busy_ff && (cnt_ff == 16'h0001);

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      cnt_ff <= 16'h0000;
      busy_ff <= 1'b0;
    end
    else if (tif.load)
    begin
      cnt_ff <= tif.count;
      busy_ff <= 1'b1;
    end
    else if (busy_ff)
    begin
      cnt_ff <= cnt_ff - 16'h0001;
      busy_ff <= (cnt_ff != 16'h0001);
    end
  end
endmodule

// [pfb_host.sv]
// Function
// - reads drive select and output gate low, write strobe high.
// - writes drive strobe and select low with output gate high.
// - bypass programming issues exactly two write cycles.
// - buffer loads limited to sixteen words or thirty-two bytes.
// - boost output raised only during accelerated programming.
// - an operation interrupted by restart is reissued afterwards.
`timescale 1ns/1ps
`include "pfb_regs.svh"
module pfb_host (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic req_valid,
  output logic req_ready,
  input wire pfb_pkg::pfb_op_t req_op,
  input wire logic [21:0] req_addr,
  input wire logic req_lsb,
  input wire logic [15:0] req_wdata,
  input wire logic byte_mode,
  input wire logic restart_req,
  output logic rsp_valid,
  output logic [15:0] rsp_rdata,
  output logic rsp_refused,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic flash_restart_n,
  output logic flash_width_select_n,
  output logic flash_boost_en,
  output logic [21:0] flash_addr,
  output logic [15:0] flash_dq_o,
  output logic [15:0] flash_dq_oe,
  input wire logic [15:0] flash_dq_i
);
  import pfb_pkg::*;

  pfb_tmr_if tif ();

  pfb_timer u_timer (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .tif(tif)
  );

  pfb_state_t state_ff;
  pfb_state_t nxt_state;
  pfb_op_t cur_op_ff;
  logic [21:0] cur_addr_ff;
  logic cur_lsb_ff;
  logic [15:0] cur_wdata_ff;
  logic mode_ff;
  logic live_ff;
  logic phase_ff;
  logic nxt_phase;
  logic page_open_ff;
  logic nxt_page_open;
  logic [5:0] buf_cnt_ff;
  logic [15:0] dq_meta_ff;
  logic [15:0] dq_sync_ff;
  logic rsp_valid_ff;
  logic rsp_refused_ff;
  logic [15:0] rdata_ff;
  logic ce_n_ff;
  logic oe_n_ff;
  logic we_n_ff;
  logic restart_n_ff;
  logic boost_ff;
  logic [21:0] addr_ff;
  logic [15:0] dq_o_ff;
  logic [15:0] dq_oe_ff;

  logic accept;
  logic page_hit;
  logic buf_full;
  logic is_pair;
  logic wr_nxt;
  logic use_setup;
  logic sel_mode;
  logic sel_lsb;
  logic [21:0] sel_addr;
  logic [15:0] wr_data;
  logic [15:0] rd_full;

  assign req_ready = (state_ff == pfb_s_idle) && !restart_req;
  assign accept = req_valid && req_ready;
  assign is_pair = (cur_op_ff == pfb_op_pair) || (cur_op_ff == pfb_op_accel);
  // reopening after select went high must wait the longer of both access times
  assign rd_full = (`PFB_CYC_SELECT > `PFB_CYC_RANDOM) ? 16'(`PFB_CYC_SELECT + `PFB_SYNC_CYC)
                                                       : 16'(`PFB_CYC_RANDOM + `PFB_SYNC_CYC);
  assign page_hit = page_open_ff && (req_addr[21:2] == cur_addr_ff[21:2])
                    && (byte_mode == mode_ff);
  assign buf_full = buf_cnt_ff >= (byte_mode ? `PFB_BUF_BYTES : `PFB_BUF_WORDS);
  assign sel_mode = accept ? byte_mode : mode_ff;
  assign sel_lsb = accept ? req_lsb : cur_lsb_ff;
  assign wr_nxt = (nxt_state == pfb_s_wsu) || (nxt_state == pfb_s_wlo)
                  || (nxt_state == pfb_s_whi);
  assign use_setup = is_pair && !nxt_phase && wr_nxt;
  assign sel_addr = use_setup ? `PFB_PAIR_SETUP_ADDR : (accept ? req_addr : cur_addr_ff);
  assign wr_data = use_setup ? `PFB_PAIR_SETUP_DATA : cur_wdata_ff;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_phase = phase_ff;
    tif.load = 1'b0;
    tif.count = 16'h0001;
    case (state_ff)
      pfb_s_idle:
        if (accept)
        begin
          nxt_phase = 1'b0;
          if (req_op == pfb_op_read)
          begin
            nxt_state = pfb_s_rd;
            tif.load = 1'b1;
            if (page_hit)
              tif.count = 16'(`PFB_CYC_PAGE + `PFB_SYNC_CYC);
            else if (page_open_ff)
              tif.count = 16'(`PFB_CYC_RANDOM + `PFB_SYNC_CYC);
            else
              tif.count = rd_full;
          end
          else if (req_op == pfb_op_restart)
            nxt_state = pfb_s_rlo;
          else if ((req_op == pfb_op_bufld) && buf_full)
            nxt_state = pfb_s_rsp;
          else
          begin
            nxt_state = pfb_s_turn;
            tif.load = 1'b1;
            tif.count = 16'(`PFB_CYC_TURN);
          end
        end
      pfb_s_rd:
        if (tif.done)
          nxt_state = pfb_s_rsp;
      pfb_s_turn:
        if (tif.done)
        begin
          nxt_state = pfb_s_wsu;
          tif.load = 1'b1;
          tif.count = 16'(`PFB_CYC_WSETUP);
        end
      pfb_s_wsu:
        if (tif.done)
        begin
          nxt_state = pfb_s_wlo;
          tif.load = 1'b1;
          tif.count = 16'(`PFB_CYC_WPULSE);
        end
      pfb_s_wlo:
        if (tif.done)
        begin
          nxt_state = pfb_s_whi;
          tif.load = 1'b1;
          tif.count = 16'(`PFB_CYC_WHOLD);
        end
      pfb_s_whi:
        if (tif.done)
        begin
          if (is_pair && !phase_ff)
          begin
            nxt_phase = 1'b1;
            nxt_state = pfb_s_wsu;
            tif.load = 1'b1;
            tif.count = 16'(`PFB_CYC_WSETUP);
          end
          else
            nxt_state = pfb_s_rsp;
        end
      pfb_s_rlo:
        if (tif.done)
        begin
          nxt_state = pfb_s_rrec;
          tif.load = 1'b1;
          tif.count = 16'(`PFB_CYC_RECOVER);
        end
      pfb_s_rrec:
        if (tif.done)
        begin
          nxt_phase = 1'b0;
          if (!live_ff)
            nxt_state = pfb_s_idle;
          else if (cur_op_ff == pfb_op_restart)
            nxt_state = pfb_s_rsp;
          else if (cur_op_ff == pfb_op_read)
          begin
            nxt_state = pfb_s_rd;
            tif.load = 1'b1;
            tif.count = rd_full;
          end
          else
          begin
            nxt_state = pfb_s_turn;
            tif.load = 1'b1;
            tif.count = 16'(`PFB_CYC_TURN);
          end
        end
      default:
        nxt_state = pfb_s_idle;
    endcase
    // restart preempts everything; the timer is reloaded for the full pulse
    if ((restart_req || (nxt_state == pfb_s_rlo)) && (state_ff != pfb_s_rlo))
    begin
      nxt_state = pfb_s_rlo;
      tif.load = 1'b1;
      tif.count = 16'(`PFB_CYC_RESTART);
    end
  end

  // page stays open with select and gate low so the next hit is fast
  always_comb
  begin
    nxt_page_open = page_open_ff;
    if (nxt_state == pfb_s_rd)
      nxt_page_open = 1'b1;
    else if (nxt_state != pfb_s_idle && nxt_state != pfb_s_rsp)
      nxt_page_open = 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      state_ff <= pfb_s_idle;
      phase_ff <= 1'b0;
      page_open_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      phase_ff <= nxt_phase;
      page_open_ff <= nxt_page_open;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      cur_op_ff <= pfb_op_read;
      cur_addr_ff <= 22'h000000;
      cur_lsb_ff <= 1'b0;
      cur_wdata_ff <= 16'h0000;
      mode_ff <= 1'b0;
    end
    else if (accept)
    begin
      cur_op_ff <= req_op;
      cur_addr_ff <= req_addr;
      cur_lsb_ff <= req_lsb;
      cur_wdata_ff <= req_wdata;
      mode_ff <= byte_mode;
    end
  end

  // live marks an op still owed a response; a restart in flight reissues it
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      live_ff <= 1'b0;
    else if (nxt_state == pfb_s_rsp)
      live_ff <= 1'b0;
    else if (accept)
      live_ff <= 1'b1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      buf_cnt_ff <= 6'h00;
    else if (nxt_state == pfb_s_rlo)
      buf_cnt_ff <= 6'h00;
    else if (accept && (req_op == pfb_op_bufld) && !buf_full)
      buf_cnt_ff <= buf_cnt_ff + 6'h01;
    else if (accept && (req_op == pfb_op_write))
      buf_cnt_ff <= 6'h00;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      dq_meta_ff <= 16'h0000;
      dq_sync_ff <= 16'h0000;
    end
    else
    begin
      dq_meta_ff <= flash_dq_i;
      dq_sync_ff <= dq_meta_ff;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      rsp_valid_ff <= 1'b0;
      rsp_refused_ff <= 1'b0;
      rdata_ff <= 16'h0000;
    end
    else
    begin
      rsp_valid_ff <= (nxt_state == pfb_s_rsp);
      rsp_refused_ff <= (nxt_state == pfb_s_rsp) && (state_ff == pfb_s_idle);
      if ((state_ff == pfb_s_rd) && tif.done)
        rdata_ff <= mode_ff ? {8'h00, dq_sync_ff[7:0]} : dq_sync_ff;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      ce_n_ff <= 1'b1;
      oe_n_ff <= 1'b1;
      we_n_ff <= 1'b1;
      restart_n_ff <= 1'b1;
      boost_ff <= 1'b0;
      addr_ff <= 22'h000000;
      dq_o_ff <= 16'h0000;
      dq_oe_ff <= 16'h0000;
    end
    else
    begin
      ce_n_ff <= !(nxt_page_open || wr_nxt);
      oe_n_ff <= !nxt_page_open;
      we_n_ff <= !(nxt_state == pfb_s_wlo);
      restart_n_ff <= !(nxt_state == pfb_s_rlo);
      boost_ff <= wr_nxt && (cur_op_ff == pfb_op_accel);
      addr_ff <= sel_addr;
      if (sel_mode)
      begin
        // top line is an address input in byte mode, so it is driven always
        dq_o_ff <= {sel_lsb && !use_setup, 7'h00, wr_data[7:0]};
        dq_oe_ff <= {1'b1, 7'h00, {8{wr_nxt}}};
      end
      else
      begin
        dq_o_ff <= wr_data;
        dq_oe_ff <= {16{wr_nxt}};
      end
    end
  end

  assign rsp_valid = rsp_valid_ff;
  assign rsp_refused = rsp_refused_ff;
  assign rsp_rdata = rdata_ff;
  assign flash_ce_n = ce_n_ff;
  assign flash_oe_n = oe_n_ff;
  assign flash_we_n = we_n_ff;
  assign flash_restart_n = restart_n_ff;
  assign flash_width_select_n = !mode_ff;
  assign flash_boost_en = boost_ff;
  assign flash_addr = addr_ff;
  assign flash_dq_o = dq_o_ff;
  assign flash_dq_oe = dq_oe_ff;
endmodule

// [pfb_flash_model.sv]
`timescale 1ns/1ps
module pfb_flash_model #(
  parameter int DLY = 20
) (
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic restart_n,
  input wire logic width_select_n,
  input wire logic boost_en,
  input wire logic [21:0] addr,
  input wire logic [15:0] dq_o,
  input wire logic [15:0] dq_oe,
  output logic [15:0] dq_i
);
  logic [15:0] mem [0:15];
  logic [15:0] drv_q;
  logic [15:0] drv_m;
  logic tog = 1'b0;
  // edge protect floats high when unconnected
  logic prot_n = 1'b1;
  // array starts erased, as after a whole-array erase
  initial
  begin
    foreach (mem[i])
      mem[i] = 16'hffff;
  end
  always #8 tog = ~tog;
  // array read from power-up, no command modes modelled
  // boosted or not, each write cycle programs, so two-cycle pairs land
  // a write lands on the strobe's rise; a later deselect does not cut it
  always @(posedge we_n)
    if (!ce_n && oe_n && restart_n && prot_n)
      if (width_select_n)
        mem[addr[3:0]] <= dq_o;
      else if (dq_o[15])
        mem[addr[3:0]][15:8] <= dq_o[7:0];
      else
        mem[addr[3:0]][7:0] <= dq_o[7:0];
  // autoselect reads share array read timing, so one read path serves both
  // data stays latched while the address holds still
  assign #(DLY) drv_q = width_select_n ? mem[addr[3:0]] :
    {8'h00, dq_o[15] ? mem[addr[3:0]][15:8] : mem[addr[3:0]][7:0]};
  // floats in standby, output disable and restart
  assign #(DLY) drv_m = (!ce_n && !oe_n && we_n && restart_n) ?
    (width_select_n ? 16'hffff : 16'h00ff) : 16'h0000;
  // undriven lines toggle so a stale value never passes
  assign dq_i = (dq_oe & dq_o) | (~dq_oe & drv_m & drv_q) | (~dq_oe & ~drv_m & {8{tog, ~tog}});
endmodule

// [pfb_host_asserts.sv]
`timescale 1ns/1ps
`include "pfb_regs.svh"
module pfb_host_asserts (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire pfb_pkg::pfb_op_t req_op,
  input wire logic rsp_valid,
  input wire logic rsp_refused,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic flash_restart_n,
  input wire logic flash_width_select_n,
  input wire logic flash_boost_en,
  input wire logic [15:0] flash_dq_oe
);
  import pfb_pkg::*;
  logic [7:0] low_cnt_ff;
  logic [2:0] we_cnt_ff;
  logic wide_op_ff;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  always_ff @(posedge sys_clk)
    if (!reset_n || flash_restart_n)
      low_cnt_ff <= 8'h00;
    else if (low_cnt_ff != 8'hff)
      low_cnt_ff <= low_cnt_ff + 8'h01;
  // cleared on restart since an interrupted pair is reissued whole
  always_ff @(posedge sys_clk)
    if (!reset_n || !flash_restart_n || (req_valid && req_ready))
      we_cnt_ff <= 3'h0;
    else if ($fell(flash_we_n))
      we_cnt_ff <= we_cnt_ff + 3'h1;
  always_ff @(posedge sys_clk)
    if (req_valid && req_ready)
      wide_op_ff <= (req_op == pfb_op_pair) || (req_op == pfb_op_accel);
  AST_READ_STROBES: assert property (!flash_oe_n |-> flash_we_n && !flash_ce_n)
    else $error("output gate low without select or with strobe");
  AST_WRITE_STROBES: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n)
    else $error("write strobe with bad select or gate");
  AST_WORD_LINES: assert property (flash_width_select_n && !flash_we_n |-> flash_dq_oe == 16'hffff)
    else $error("word write not on all lines");
  AST_BYTE_LINES: assert property (!flash_width_select_n |-> flash_dq_oe[15] && flash_dq_oe[14:8] == 7'h00)
    else $error("byte mode line drive wrong");
  AST_BOOST_WRITE_ONLY: assert property (flash_boost_en |-> flash_oe_n)
    else $error("boost raised during a read");
  AST_RESTART_WIDTH: assert property ($rose(flash_restart_n) |-> low_cnt_ff >= `PFB_CYC_RESTART)
    else $error("restart pulse too short");
  AST_RESTART_QUIET: assert property (!flash_restart_n |-> flash_ce_n && flash_dq_oe[14:0] == 15'h0000)
    else $error("bus active during restart");
  AST_FIRST_READ_WAIT: assert property ($fell(flash_oe_n) |-> ##1 !rsp_valid [*8])
    else $error("first read answered too early");
  AST_PAIR_TWO_WRITES: assert property (rsp_valid && wide_op_ff |-> we_cnt_ff == 3'h2)
    else $error("bypass program not two write cycles");
  AST_REFUSED_NO_CYCLE: assert property (rsp_valid && rsp_refused |-> we_cnt_ff == 3'h0)
    else $error("refused buffer load reached the bus");
endmodule
bind pfb_host pfb_host_asserts pfb_host_asserts_inst (.sys_clk(sys_clk), .reset_n(reset_n),
  .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op), .rsp_valid(rsp_valid),
  .rsp_refused(rsp_refused), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
  .flash_we_n(flash_we_n), .flash_restart_n(flash_restart_n),
  .flash_width_select_n(flash_width_select_n), .flash_boost_en(flash_boost_en),
  .flash_dq_oe(flash_dq_oe));

// [testbench.sv]
`timescale 1ns/1ps
module testbench;
  import pfb_pkg::*;
  typedef struct {pfb_op_t op; logic [21:0] a; logic b; logic l; logic [15:0] d;} pfb_row_t;
  logic sys_clk = 1'b0, reset_n = 1'b0, req_valid = 1'b0, req_lsb = 1'b0;
  logic byte_mode = 1'b0, restart_req = 1'b0;
  logic [21:0] req_addr = 22'h000000;
  logic [15:0] req_wdata = 16'h0000;
  pfb_op_t req_op = pfb_op_read;
  logic req_ready, rsp_valid, rsp_refused, ce_n, oe_n, we_n, rst_n, wsel_n, boost;
  logic [21:0] faddr;
  logic [15:0] rsp_rdata, dq_o, dq_oe, dq_i;
  int failures = 0, n_compared = 0;
  pfb_row_t rows [13] = '{
    '{pfb_op_write, 22'h000005, 1'b0, 1'b0, 16'h1234}, '{pfb_op_write, 22'h000006, 1'b0, 1'b0, 16'habcd},
    '{pfb_op_write, 22'h000007, 1'b0, 1'b0, 16'h7777}, '{pfb_op_read, 22'h000005, 1'b0, 1'b0, 16'h1234},
    '{pfb_op_read, 22'h000006, 1'b0, 1'b0, 16'habcd}, '{pfb_op_read, 22'h000007, 1'b0, 1'b0, 16'h7777},
    '{pfb_op_pair, 22'h000009, 1'b0, 1'b0, 16'h5a5a}, '{pfb_op_read, 22'h000009, 1'b0, 1'b0, 16'h5a5a},
    '{pfb_op_accel, 22'h00000a, 1'b0, 1'b0, 16'h0f0f}, '{pfb_op_read, 22'h00000a, 1'b0, 1'b0, 16'h0f0f},
    '{pfb_op_read, 22'h000005, 1'b1, 1'b1, 16'h0012}, '{pfb_op_read, 22'h000005, 1'b1, 1'b0, 16'h0034},
    '{pfb_op_read, 22'h000006, 1'b1, 1'b1, 16'h00ab}};
  pfb_host pfb_host_inst (.sys_clk(sys_clk), .reset_n(reset_n), .req_valid(req_valid),
    .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr), .req_lsb(req_lsb),
    .req_wdata(req_wdata), .byte_mode(byte_mode), .restart_req(restart_req),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_refused(rsp_refused),
    .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_restart_n(rst_n),
    .flash_width_select_n(wsel_n), .flash_boost_en(boost), .flash_addr(faddr),
    .flash_dq_o(dq_o), .flash_dq_oe(dq_oe), .flash_dq_i(dq_i));
  pfb_flash_model #(.DLY(20)) pfb_flash_model_inst (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .restart_n(rst_n), .width_select_n(wsel_n), .boost_en(boost), .addr(faddr),
    .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i));
  initial
  begin
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic conclude;
    if (failures == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // rs above zero pulses restart that many cycles after the take
  task automatic do_req(input pfb_op_t op, input logic [21:0] a, input logic l, input logic b,
    input logic [15:0] d, input int rs);
    int n;
    n = 0;
    req_op = op;
    req_addr = a;
    req_lsb = l;
    byte_mode = b;
    req_wdata = d;
    req_valid = 1'b1;
    while (req_ready !== 1'b1 && n < 300)
    begin
      @(posedge sys_clk);
      #1 n++;
    end
    @(posedge sys_clk);
    #1 req_valid = 1'b0;
    if (rs > 0)
    begin
      repeat (rs) @(posedge sys_clk);
      #1 restart_req = 1'b1;
      @(posedge sys_clk);
      #1 restart_req = 1'b0;
    end
    while (rsp_valid !== 1'b1 && n < 300)
    begin
      @(posedge sys_clk);
      #1 n++;
    end
    if (n >= 300)
    begin
      failures++;
      conclude;
    end
  endtask
  initial
  begin
    repeat (10) @(posedge sys_clk);
    #1 chk("idle pins", {ce_n, oe_n, we_n, rst_n, wsel_n, boost, 10'h000}, 16'hf800);
    chk("idle drive", dq_oe, 16'h0000);
    reset_n = 1'b1;
    foreach (rows[i])
    begin
      do_req(rows[i].op, rows[i].a, rows[i].l, rows[i].b, rows[i].d, 0);
      if (rows[i].op == pfb_op_read)
        chk("read data", rsp_rdata, rows[i].d);
      chk("refused", {15'h0000, rsp_refused}, 16'h0000);
    end
    do_req(pfb_op_read, 22'h000006, 1'b0, 1'b0, 16'h0000, 5);
    chk("read after restart", rsp_rdata, 16'habcd);
    do_req(pfb_op_restart, 22'h000000, 1'b0, 1'b0, 16'h0000, 0);
    do_req(pfb_op_read, 22'h000007, 1'b0, 1'b0, 16'h0000, 0);
    chk("read after restart op", rsp_rdata, 16'h7777);
    for (int k = 0; k < 2; k++)
    begin
      do_req(pfb_op_write, 22'h00000e, 1'b0, k[0], 16'h0000, 0);
      for (int j = 0; j <= (16 << k); j++)
      begin
        do_req(pfb_op_bufld, 22'h00000f, j[0], k[0], 16'h00c3, 0);
        chk("buffer refusal", {15'h0000, rsp_refused}, {15'h0000, j == (16 << k)});
      end
    end
    conclude;
  end
endmodule
